// File: design/bsr_unit.sv
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
// What this block does
// RULE1: logical right shift of working register: zero into bit 7, old bit 0 to carry.
// RULE2: rotate right working register through carry: carry into bit 7, bit 0 to carry.
// RULE3: logical right shift of memory byte written back, old bit 0 to carry.
// RULE4: rotate right memory byte through carry, written back, old bit 0 to carry.
// RULE5: logical left shift of working register: zero into bit 0, old bit 7 to carry.
// RULE6: rotate left working register through carry: carry into bit 0, bit 7 to carry.
// RULE7: logical left shift of memory byte written back, old bit 7 to carry.
// RULE8: rotate left memory byte through carry, written back, old bit 7 to carry.
// RULE9: nibble swap of working register exchanges high and low halves at once.
// RULE10: every shift or rotate changes carry only; zero, aux carry, overflow hold.
// RULE11: nibble swap leaves zero, carry, aux carry and overflow untouched.
// RULE12: memory shifts are read-modify-write of one address within one operation.
module bsr_unit
  import bsr_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [7:0] working_register,
  output logic carry_flag,
  output logic zero_flag,
  output logic aux_carry_flag,
  output logic overflow_flag,
  output logic busy
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    bsr_seq_t seq;
    logic [3:0] op;
    logic [7:0] work;
    logic [3:0] flags;
    logic [AW-1:0] maddr;
    logic [7:0] mbuf;
    logic wait_req;
    logic busy;
    logic [31:0] rdata;
  } bsr_unit_state_t;

  localparam bsr_unit_state_t BSR_UNIT_RST = '{
    seq: BSR_ST_IDLE,
    op: BSR_OP_NOP,
    work: BSR_WORK_RST,
    flags: BSR_FLAGS_RST,
    maddr: '0,
    mbuf: BSR_MEM_RST,
    wait_req: 1'b1,
    busy: 1'b0,
    rdata: BSR_RDATA_RST
  };

  bsr_unit_state_t state_ff;
  bsr_unit_state_t nxt_state;

  logic [7:0] core_operand;
  logic [7:0] core_result;
  logic core_cout;
  logic core_cupd;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] mem_rd;
  logic aligned;
  logic lane0;
  logic is_busy;
  logic commit_wr;
  logic [31:0] read_mux;

  // ---------------------------------------------------------------
  // datapath and storage
  // ---------------------------------------------------------------
  assign core_operand = bsr_is_mem_op(state_ff.op) ? state_ff.mbuf : state_ff.work;

  bsr_shift_core u_core (
    .op(state_ff.op),
    .operand(core_operand),
    .carry_in(state_ff.flags[BSR_FLG_CARRY_BIT]),
    .result(core_result),
    .carry_out(core_cout),
    .carry_upd(core_cupd)
  );

  bsr_dmem #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_dmem (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(state_ff.maddr),
    .rd_data(mem_rd)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign aligned = (avs_address[1:0] == 2'h0);
  assign lane0 = avs_byteenable[0];
  assign is_busy = state_ff.busy;
  // writes land only in the cycle where waitrequest is low, so the master sees them at that edge
  assign commit_wr = !state_ff.wait_req && avs_write && aligned && lane0;

  always_comb begin
    read_mux = 32'h00000000;
    if (aligned) begin
      case (avs_address)
        BSR_OFF_CMD: read_mux = {28'h0000000, state_ff.op};
        BSR_OFF_WORK: read_mux = {24'h000000, state_ff.work};
        BSR_OFF_FLAGS: read_mux = {28'h0000000, state_ff.flags};
        BSR_OFF_MADDR: read_mux = {{(32 - AW){1'b0}}, state_ff.maddr};
        BSR_OFF_MDATA: read_mux = {24'h000000, mem_rd};
        BSR_OFF_STATUS: begin
          read_mux[BSR_STAT_BUSY_BIT] = is_busy;
          read_mux[BSR_STAT_OP_LSB +: BSR_OP_W] = state_ff.op;
        end
        default: read_mux = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // memory port: sequencer write-back has priority by construction,
  // because bus writes are only committed while idle
  // ---------------------------------------------------------------
  always_comb begin
    mem_we = 1'b0;
    mem_wa = state_ff.maddr;
    mem_wd = avs_writedata[7:0];
    if (state_ff.seq == BSR_ST_MEM_WRITE) begin
      mem_we = 1'b1; // RULE12
      mem_wd = core_result; // RULE3 RULE4 RULE7 RULE8
    end else if (commit_wr && (avs_address == BSR_OFF_MDATA)) begin
      mem_we = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // bus handshake, register writes and sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    if (state_ff.wait_req) begin
      if (avs_read) begin
        nxt_state.wait_req = 1'b0;
        nxt_state.rdata = read_mux;
      end else if (avs_write && !is_busy) begin
        // writes stall while an operation runs so no field changes under it
        nxt_state.wait_req = 1'b0;
      end
    end else begin
      nxt_state.wait_req = 1'b1;
    end

    if (commit_wr) begin
      case (avs_address)
        BSR_OFF_CMD: begin
          nxt_state.op = avs_writedata[BSR_OP_W-1:0];
          if (bsr_is_mem_op(avs_writedata[BSR_OP_W-1:0])) begin
            nxt_state.seq = BSR_ST_MEM_READ;
          end else if (bsr_is_work_op(avs_writedata[BSR_OP_W-1:0])) begin
            nxt_state.seq = BSR_ST_EXEC;
          end
        end
        BSR_OFF_WORK: nxt_state.work = avs_writedata[7:0];
        BSR_OFF_FLAGS: nxt_state.flags = avs_writedata[3:0];
        BSR_OFF_MADDR: nxt_state.maddr = avs_writedata[AW-1:0];
        default: nxt_state.seq = state_ff.seq;
      endcase
    end

    case (state_ff.seq)
      BSR_ST_IDLE: begin
        nxt_state.mbuf = state_ff.mbuf;
      end
      BSR_ST_EXEC: begin
        nxt_state.work = core_result; // RULE1 RULE2 RULE5 RULE6 RULE9
        if (core_cupd) begin
          nxt_state.flags[BSR_FLG_CARRY_BIT] = core_cout; // RULE10 RULE11
        end
        nxt_state.seq = BSR_ST_IDLE;
      end
      BSR_ST_MEM_READ: begin
        nxt_state.mbuf = mem_rd; // RULE12
        nxt_state.seq = BSR_ST_MEM_WRITE;
      end
      BSR_ST_MEM_WRITE: begin
        if (core_cupd) begin
          nxt_state.flags[BSR_FLG_CARRY_BIT] = core_cout; // RULE10
        end
        nxt_state.seq = BSR_ST_IDLE;
      end
      default: begin
        nxt_state.seq = BSR_ST_IDLE;
      end
    endcase
    // busy is a flop of its own so the output pin carries no decode logic
    nxt_state.busy = (nxt_state.seq != BSR_ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= BSR_UNIT_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_readdata = state_ff.rdata;
  assign avs_waitrequest = state_ff.wait_req;
  assign working_register = state_ff.work;
  assign carry_flag = state_ff.flags[BSR_FLG_CARRY_BIT];
  assign zero_flag = state_ff.flags[BSR_FLG_ZERO_BIT];
  assign aux_carry_flag = state_ff.flags[BSR_FLG_AUX_BIT];
  assign overflow_flag = state_ff.flags[BSR_FLG_OVF_BIT];
  assign busy = is_busy;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic [7:0] w;
  logic [7:0] mb;
  logic c;
  assign w = state_ff.work;
  assign mb = state_ff.mbuf;
  assign c = state_ff.flags[BSR_FLG_CARRY_BIT];

  function automatic logic exec_of(input bsr_seq_t s, input logic [3:0] o, input logic [3:0] want);
    exec_of = (s == BSR_ST_EXEC) && (o == want);
  endfunction

  sequence s_mem_read(logic [3:0] want);
    (state_ff.seq == BSR_ST_MEM_READ) && (state_ff.op == want);
  endsequence

  sequence s_mem_write;
    (state_ff.seq == BSR_ST_MEM_WRITE) && mem_we && (mem_wa == state_ff.maddr);
  endsequence

  shr_work_a: assert property (exec_of(state_ff.seq, state_ff.op, BSR_OP_SHR_WORK) |=> // RULE1
    (w == {1'b0, $past(w[7:1])}) && (c == $past(w[0])))
    else $error("logical right shift of working register wrong");

  rrc_work_a: assert property (exec_of(state_ff.seq, state_ff.op, BSR_OP_RRC_WORK) |=> // RULE2
    (w == {$past(c), $past(w[7:1])}) && (c == $past(w[0])))
    else $error("rotate right of working register wrong");

  shl_work_a: assert property (exec_of(state_ff.seq, state_ff.op, BSR_OP_SHL_WORK) |=> // RULE5
    (w == {$past(w[6:0]), 1'b0}) && (c == $past(w[7])))
    else $error("logical left shift of working register wrong");

  rlc_work_a: assert property (exec_of(state_ff.seq, state_ff.op, BSR_OP_RLC_WORK) |=> // RULE6
    (w == {$past(w[6:0]), $past(c)}) && (c == $past(w[7])))
    else $error("rotate left of working register wrong");

  swap_work_a: assert property (exec_of(state_ff.seq, state_ff.op, BSR_OP_SWAP_WORK) |=> // RULE9
    w == {$past(w[3:0]), $past(w[7:4])})
    else $error("nibble swap of working register wrong");

  swap_flags_a: assert property (exec_of(state_ff.seq, state_ff.op, BSR_OP_SWAP_WORK) |=> // RULE11
    $stable(state_ff.flags))
    else $error("nibble swap changed a flag");

  shr_mem_a: assert property (s_mem_read(BSR_OP_SHR_MEM) ##1 s_mem_write |-> // RULE3
    (mem_wd == {1'b0, mb[7:1]}) ##1 (c == $past(mb[0])))
    else $error("logical right shift of memory byte wrong");

  rrc_mem_a: assert property (s_mem_read(BSR_OP_RRC_MEM) ##1 s_mem_write |-> // RULE4
    (mem_wd == {c, mb[7:1]}) ##1 (c == $past(mb[0])))
    else $error("rotate right of memory byte wrong");

  shl_mem_a: assert property (s_mem_read(BSR_OP_SHL_MEM) ##1 s_mem_write |-> // RULE7
    (mem_wd == {mb[6:0], 1'b0}) ##1 (c == $past(mb[7])))
    else $error("logical left shift of memory byte wrong");

  rlc_mem_a: assert property (s_mem_read(BSR_OP_RLC_MEM) ##1 s_mem_write |-> // RULE8
    (mem_wd == {mb[6:0], c}) ##1 (c == $past(mb[7])))
    else $error("rotate left of memory byte wrong");

  shift_flags_a: assert property (core_cupd && // RULE10
    ((state_ff.seq == BSR_ST_EXEC) || (state_ff.seq == BSR_ST_MEM_WRITE)) |=>
    $stable(state_ff.flags[BSR_FLG_ZERO_BIT]) && $stable(state_ff.flags[BSR_FLG_AUX_BIT]) &&
    $stable(state_ff.flags[BSR_FLG_OVF_BIT]))
    else $error("shift changed a flag other than carry");

  mem_rmw_a: assert property ((state_ff.seq == BSR_ST_MEM_READ) |=> // RULE12
    (mb == $past(mem_rd)) && (state_ff.seq == BSR_ST_MEM_WRITE) && $stable(state_ff.maddr)
    ##1 (state_ff.seq == BSR_ST_IDLE))
    else $error("memory read-modify-write sequence broken");

  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // reads are never held off, not even while an operation runs
  read_answer_a: assert property (avs_waitrequest && avs_read |=> !avs_waitrequest)
    else $error("read not answered in the next cycle");

  // a write answered mid-operation could change an operand under the datapath
  write_stall_a: assert property (busy && avs_waitrequest && avs_write && !avs_read |=> avs_waitrequest)
    else $error("write answered while an operation runs");

  flags_idle_a: assert property (!busy && !commit_wr |=> $stable(state_ff.flags))
    else $error("flags changed with no operation and no write");

  // a command write lands in the cycle in which its waitrequest is low
  sequence s_cmd_commit;
    commit_wr && (avs_address == BSR_OFF_CMD);
  endsequence

  work_busy_a: assert property (s_cmd_commit ##0 bsr_is_work_op(avs_writedata[BSR_OP_W-1:0]) |=>
    busy ##1 !busy)
    else $error("working register operation not one cycle long");

  mem_busy_a: assert property (s_cmd_commit ##0 bsr_is_mem_op(avs_writedata[BSR_OP_W-1:0]) |=> // RULE12
    busy ##1 busy ##1 !busy)
    else $error("memory operation not two cycles long");

  nop_idle_a: assert property (s_cmd_commit ##0 (!bsr_is_mem_op(avs_writedata[BSR_OP_W-1:0]) &&
    !bsr_is_work_op(avs_writedata[BSR_OP_W-1:0])) |=> !busy)
    else $error("unknown command started an operation");

  mem_work_a: assert property ((state_ff.seq == BSR_ST_MEM_READ) |=> $stable(w) ##1 $stable(w)) // RULE12
    else $error("memory operation changed the working register");

endmodule

// File: design/bsr_pkg.sv
package bsr_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] BSR_OFF_CMD = 8'h00;
  localparam logic [7:0] BSR_OFF_WORK = 8'h04;
  localparam logic [7:0] BSR_OFF_FLAGS = 8'h08;
  localparam logic [7:0] BSR_OFF_MADDR = 8'h0C;
  localparam logic [7:0] BSR_OFF_MDATA = 8'h10;
  localparam logic [7:0] BSR_OFF_STATUS = 8'h14;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BSR_FLG_ZERO_BIT = 0;
  localparam int BSR_FLG_CARRY_BIT = 1;
  localparam int BSR_FLG_AUX_BIT = 2;
  localparam int BSR_FLG_OVF_BIT = 3;
  localparam int BSR_STAT_BUSY_BIT = 0;
  localparam int BSR_STAT_OP_LSB = 4;
  localparam int BSR_OP_W = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] BSR_WORK_RST = 8'h00;
  localparam logic [3:0] BSR_FLAGS_RST = 4'h0;
  localparam logic [7:0] BSR_MEM_RST = 8'h00;
  localparam logic [31:0] BSR_RDATA_RST = 32'h00000000;

  // ---------------------------------------------------------------
  // operation codes written to the command register
  // ---------------------------------------------------------------
  localparam logic [3:0] BSR_OP_NOP = 4'h0;
  localparam logic [3:0] BSR_OP_SHR_WORK = 4'h1;
  localparam logic [3:0] BSR_OP_RRC_WORK = 4'h2;
  localparam logic [3:0] BSR_OP_SHR_MEM = 4'h3;
  localparam logic [3:0] BSR_OP_RRC_MEM = 4'h4;
  localparam logic [3:0] BSR_OP_SHL_WORK = 4'h5;
  localparam logic [3:0] BSR_OP_RLC_WORK = 4'h6;
  localparam logic [3:0] BSR_OP_SHL_MEM = 4'h7;
  localparam logic [3:0] BSR_OP_RLC_MEM = 4'h8;
  localparam logic [3:0] BSR_OP_SWAP_WORK = 4'h9;

  typedef enum logic [1:0] {
    BSR_ST_IDLE,
    BSR_ST_EXEC,
    BSR_ST_MEM_READ,
    BSR_ST_MEM_WRITE
  } bsr_seq_t;

  function automatic logic bsr_is_mem_op(input logic [3:0] op);
    bsr_is_mem_op = (op == BSR_OP_SHR_MEM) || (op == BSR_OP_RRC_MEM) ||
                    (op == BSR_OP_SHL_MEM) || (op == BSR_OP_RLC_MEM);
  endfunction

  function automatic logic bsr_is_work_op(input logic [3:0] op);
    bsr_is_work_op = (op == BSR_OP_SHR_WORK) || (op == BSR_OP_RRC_WORK) ||
                     (op == BSR_OP_SHL_WORK) || (op == BSR_OP_RLC_WORK) ||
                     (op == BSR_OP_SWAP_WORK);
  endfunction

endpackage

// File: design/bsr_shift_core.sv
`timescale 1ns/1ps
module bsr_shift_core
  import bsr_pkg::*;
(
  input wire logic [3:0] op,
  input wire logic [7:0] operand,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic carry_upd
);

  // ---------------------------------------------------------------
  // purely combinational; the caller decides when to commit
  // ---------------------------------------------------------------
  always_comb begin
    result = operand;
    carry_out = carry_in;
    carry_upd = 1'b0;
    case (op)
      BSR_OP_SHR_WORK, BSR_OP_SHR_MEM: begin
        result = {1'b0, operand[7:1]}; // RULE1 RULE3
        carry_out = operand[0];
        carry_upd = 1'b1;
      end
      BSR_OP_RRC_WORK, BSR_OP_RRC_MEM: begin
        result = {carry_in, operand[7:1]}; // RULE2 RULE4
        carry_out = operand[0];
        carry_upd = 1'b1;
      end
      BSR_OP_SHL_WORK, BSR_OP_SHL_MEM: begin
        result = {operand[6:0], 1'b0}; // RULE5 RULE7
        carry_out = operand[7];
        carry_upd = 1'b1;
      end
      BSR_OP_RLC_WORK, BSR_OP_RLC_MEM: begin
        result = {operand[6:0], carry_in}; // RULE6 RULE8
        carry_out = operand[7];
        carry_upd = 1'b1;
      end
      BSR_OP_SWAP_WORK: begin
        result = {operand[3:0], operand[7:4]}; // RULE9
      end
      default: begin
        result = operand;
      end
    endcase
  end

endmodule

// File: design/bsr_dmem.sv
`timescale 1ns/1ps
module bsr_dmem
  import bsr_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } bsr_dmem_state_t;

  bsr_dmem_state_t state_ff;
  bsr_dmem_state_t nxt_state;
  logic [DEPTH-1:0] hit;

  // ---------------------------------------------------------------
  // per-entry write decode
  // ---------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_hit
    assign hit[i] = wr_en && (wr_addr == AW'(i));
  end

  always_comb begin
    nxt_state = state_ff;
    for (int j = 0; j < DEPTH; j++) begin
      if (hit[j]) begin
        nxt_state.mem[j] = wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= '{mem: {DEPTH{BSR_MEM_RST}}};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // read is asynchronous from the flops so a read-modify-write fits two cycles
  assign rd_data = state_ff.mem[rd_addr];

endmodule

// File: tb/bsr_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// bus master standing in for the core's instruction decoder
// ---------------------------------------------------------------
module bsr_host_model (
  input wire logic clk,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
  end

  // no latency is assumed: the request stands until waitrequest is sampled low
  task automatic await_answer(output logic [31:0] d);
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
  endtask

  // released lines show the inverse so stale values cannot pass for fresh ones
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    logic [31:0] unused;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    await_answer(unused);
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
    avs_byteenable <= ~be;
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    await_answer(d);
    avs_read <= 1'b0;
    avs_address <= ~a;
  endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import bsr_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] working_register;
  logic carry_flag;
  logic zero_flag;
  logic aux_carry_flag;
  logic overflow_flag;
  logic busy;
  int errors = 0;
  int cmp_count = 0;
  time t0;

  always #5 clk = ~clk;

  bsr_host_model i_host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  bsr_unit #(.DEPTH(16)) i_dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .working_register(working_register), .carry_flag(carry_flag), .zero_flag(zero_flag),
    .aux_carry_flag(aux_carry_flag), .overflow_flag(overflow_flag), .busy(busy));

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_host.bus_read(a, d);
    chk(what, exp, d);
  endtask

  // carry out in bit 8, result byte below
  function automatic logic [8:0] model(input logic [3:0] op, input logic [7:0] v, input logic c);
    case (op)
      BSR_OP_SHR_WORK, BSR_OP_SHR_MEM: model = {v[0], 1'b0, v[7:1]};
      BSR_OP_RRC_WORK, BSR_OP_RRC_MEM: model = {v[0], c, v[7:1]};
      BSR_OP_SHL_WORK, BSR_OP_SHL_MEM: model = {v[7], v[6:0], 1'b0};
      BSR_OP_RLC_WORK, BSR_OP_RLC_MEM: model = {v[7], v[6:0], c};
      BSR_OP_SWAP_WORK: model = {c, v[3:0], v[7:4]};
      default: model = {c, v};
    endcase
  endfunction

  task automatic wait_idle(input int exp_cycles);
    int n;
    int k;
    n = 0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (busy === 1'b1) n++;
    end while (busy !== 1'b0 && k < 16);
    chk("busy cycles", 32'(exp_cycles), 32'(n));
  endtask

  task automatic run(input logic [3:0] op, input logic [7:0] v, input logic [3:0] f);
    logic [8:0] e;
    logic mem;
    mem = op inside {BSR_OP_SHR_MEM, BSR_OP_RRC_MEM, BSR_OP_SHL_MEM, BSR_OP_RLC_MEM};
    e = model(op, v, f[1]);
    i_host.bus_write(BSR_OFF_FLAGS, {28'h0000000, f});
    if (mem) begin
      i_host.bus_write(BSR_OFF_MADDR, 32'h0000000E);
      i_host.bus_write(BSR_OFF_MDATA, 32'h000000C3);
      i_host.bus_write(BSR_OFF_MADDR, 32'h0000000F);
      i_host.bus_write(BSR_OFF_MDATA, {24'h000000, v});
      i_host.bus_write(BSR_OFF_WORK, 32'h0000005A);
    end else begin
      i_host.bus_write(BSR_OFF_WORK, {24'h000000, v});
    end
    i_host.bus_write(BSR_OFF_CMD, {28'h0000000, op});
    wait_idle(mem ? 2 : (op inside {[4'h1:4'h9]} ? 1 : 0));
    if (mem) begin
      rd_chk("mem byte", BSR_OFF_MDATA, {24'h000000, e[7:0]});
      i_host.bus_write(BSR_OFF_MADDR, 32'h0000000E);
      rd_chk("neighbour byte", BSR_OFF_MDATA, 32'h000000C3);
      rd_chk("work kept", BSR_OFF_WORK, 32'h0000005A);
    end else begin
      rd_chk("work", BSR_OFF_WORK, {24'h000000, e[7:0]});
      chk("work port", {24'h000000, e[7:0]}, {24'h000000, working_register});
    end
    rd_chk("flags", BSR_OFF_FLAGS, {28'h0000000, f[3:2], e[8], f[0]});
    chk("flag ports", {28'h0000000, f[3:2], e[8], f[0]},
      {28'h0000000, overflow_flag, aux_carry_flag, carry_flag, zero_flag});
    rd_chk("last op", BSR_OFF_STATUS, {24'h000000, op, 4'h0});
  endtask

  task automatic reset_state();
    rd_chk("work rst", BSR_OFF_WORK, 32'h00000000);
    rd_chk("flags rst", BSR_OFF_FLAGS, 32'h00000000);
    rd_chk("status rst", BSR_OFF_STATUS, 32'h00000000);
    rd_chk("mem rst", BSR_OFF_MDATA, 32'h00000000);
    rd_chk("maddr rst", BSR_OFF_MADDR, 32'h00000000);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    reset_state();
    $display("test reset done");
    // two operand patterns give both carry values in and out for every code
    for (int o = 0; o <= 10; o++) begin
      run(4'(o), 8'h96, 4'hD);
      run(4'(o), 8'h69, 4'h2);
    end
    $display("test operations done");
    i_host.bus_write(BSR_OFF_WORK, 32'h00000024);
    i_host.bus_write(8'h18, 32'h000000FF);
    rd_chk("unmapped", 8'h18, 32'h00000000);
    i_host.bus_write(8'h05, 32'h000000FF);
    i_host.bus_write(BSR_OFF_WORK, 32'h000000FF, 4'hE);
    rd_chk("work guarded", BSR_OFF_WORK, 32'h00000024);
    $display("test refusals done");
    // a write raised during the memory write-back stalls one cycle and lands after it
    i_host.bus_write(BSR_OFF_FLAGS, 32'h00000000);
    i_host.bus_write(BSR_OFF_MADDR, 32'h00000003);
    i_host.bus_write(BSR_OFF_MDATA, 32'h00000081);
    i_host.bus_write(BSR_OFF_CMD, {28'h0000000, BSR_OP_SHL_MEM});
    t0 = $time;
    i_host.bus_write(BSR_OFF_WORK, 32'h0000003C);
    chk("stalled write cycles", 32'h00000004, 32'(($time - t0) / 10));
    rd_chk("stalled write", BSR_OFF_WORK, 32'h0000003C);
    rd_chk("stalled carry", BSR_OFF_FLAGS, 32'h00000002);
    rd_chk("stalled mem", BSR_OFF_MDATA, 32'h00000002);
    // reads are never stalled, so status shows the running operation
    i_host.bus_write(BSR_OFF_CMD, {28'h0000000, BSR_OP_RRC_MEM});
    rd_chk("status busy", BSR_OFF_STATUS, {24'h000000, BSR_OP_RRC_MEM, 4'h1});
    rd_chk("rotated mem", BSR_OFF_MDATA, 32'h00000081);
    rd_chk("rotated carry", BSR_OFF_FLAGS, 32'h00000000);
    $display("test stall done");
    i_host.bus_write(BSR_OFF_FLAGS, 32'h0000000F);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    reset_state();
    i_host.bus_write(BSR_OFF_MADDR, 32'h00000003);
    rd_chk("mem rst used byte", BSR_OFF_MDATA, 32'h00000000);
    $display("test second reset done");
    conclude();
  end

  initial begin
    repeat (8000) @(posedge clk);
    errors++;
    $display("BAD watchdog expected finish seen hang");
    conclude();
  end
endmodule
